// *** irq_reset_model.sv ***
// interrupt controller and reset logic model, counts requests
`timescale 1ns/1ps
module irq_reset_model (
  input wire logic clk,
  input wire logic top_req,
  input wire logic a0_req,
  input wire logic sys_req,
  output int n_top,
  output int n_a0,
  output int n_rst
);
  initial begin
    n_top = 0;
    n_a0 = 0;
    n_rst = 0;
  end
  // one count per request cycle; count-routed pulses are single cycles, pin-routed requests last as long as the pin
  always @(posedge clk) begin
    n_top <= n_top + int'(top_req);
    n_a0 <= n_a0 + int'(a0_req);
    n_rst <= n_rst + int'(sys_req);
  end
endmodule : irq_reset_model

// *** timer_watchdog_regs_irq.sv ***
// timer/watchdog counter, registers and interrupt/reset routing
`timescale 1ns/1ps
module timer_watchdog_regs_irq
  import wdt_pkg::*;
#(
  parameter int COUNT_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic timer_in_pin,
  input wire logic nmi_pin,
  input wire logic ext_int_pin,
  input wire logic hw_guard_select_pin,
  input wire logic top_pend_set,
  input wire logic a0_pend_set,
  output logic top_level_request,
  output logic chan_a0_request,
  output logic system_reset_req,
  output logic guard_reset_flag,
  output logic timer_out_pin
);
  logic [7:0] hi_reg, hi_next, lo_reg, lo_next, pre_reg, pre_next, ctl_reg, ctl_next;
  logic [7:0] evr_reg, evr_next;
  logic gen_n_reg, gen_n_next, hw_reg, hw_next, strap_reg, strap_next;
  logic [COUNT_W-1:0] cnt_reg, cnt_next;
  logic [7:0] pcnt_reg, pcnt_next;
  logic [1:0] div_reg, div_next;
  logic pin_reg, pin_next, trig_reg, trig_next, out_reg, out_next;
  logic top_reg, top_next, a0_reg, a0_next, srst_reg, srst_next, flag_reg, flag_next;
  logic [7:0] rd_reg, rd_next;
  key_state_t key_reg, key_next;
  logic guard, tick4, fall, src_tick, running, pre_wrap, eoc;
  logic [1:0] mode;

  function automatic logic [7:0] read_mux(input logic [7:0] a);
    unique case (a)
      ADDR_EXT_VECTOR: read_mux = {5'h0, evr_reg[BIT_TOP_SEL], evr_reg[BIT_A0_SEL], 1'b0};
      ADDR_COUNT_HI: read_mux = cnt_reg[15:8];
      ADDR_COUNT_LO: read_mux = cnt_reg[7:0];
      ADDR_PRESCALE: read_mux = pre_reg;
      ADDR_CONTROL: read_mux = ctl_reg;
      ADDR_WAIT: read_mux = {1'b0, gen_n_reg, 6'h3f};
      default: read_mux = 8'h00;
    endcase
  endfunction : read_mux

  always_comb begin
    guard = hw_reg | ~gen_n_reg;
    tick4 = (div_reg == 2'(CLK_DIV - 1));
    fall = pin_reg & ~timer_in_pin;
    mode = ctl_reg[BIT_MODE_HI:BIT_MODE_LO];
    // watchdog ignores run, single and input mode bits
    if (guard) begin
      running = 1'b1;
      src_tick = tick4;
    end else if (!ctl_reg[BIT_RUN]) begin
      running = 1'b0;
      src_tick = 1'b0;
    end else if (!ctl_reg[BIT_INPUT_EN]) begin
      running = 1'b1;
      src_tick = tick4;
    end else begin
      unique case (mode)
        MODE_EVENT: begin
          running = 1'b1;
          src_tick = fall;
        end
        MODE_GATED: begin
          running = timer_in_pin;
          src_tick = tick4 & timer_in_pin;
        end
        MODE_TRIG: begin
          running = trig_reg;
          src_tick = tick4 & trig_reg;
        end
        MODE_RETRIG: begin
          running = 1'b1;
          src_tick = tick4;
        end
      endcase
    end
    pre_wrap = src_tick && (pcnt_reg == 8'h00);
    eoc = pre_wrap && running && (cnt_reg == '0);
  end

  always_comb begin
    hi_next = hi_reg;
    lo_next = lo_reg;
    pre_next = pre_reg;
    ctl_next = ctl_reg;
    evr_next = evr_reg;
    gen_n_next = gen_n_reg;
    hw_next = hw_reg;
    strap_next = 1'b0;
    cnt_next = cnt_reg;
    pcnt_next = pcnt_reg;
    div_next = tick4 ? 2'h0 : div_reg + 2'h1;
    pin_next = timer_in_pin;
    trig_next = trig_reg;
    out_next = out_reg;
    key_next = key_reg;
    flag_next = flag_reg;
    srst_next = 1'b0;
    top_next = 1'b0;
    a0_next = 1'b0;
    rd_next = reg_rd ? read_mux(reg_addr) : rd_reg;
    // hardware guard strap caught once, just after reset release
    if (strap_reg) begin
      hw_next = ~hw_guard_select_pin;
    end
    if (!ctl_reg[BIT_RUN]) begin
      trig_next = 1'b0;
    end else if (fall) begin
      trig_next = 1'b1;
    end
    if (src_tick && running) begin
      pcnt_next = (pcnt_reg == 8'h00) ? pre_reg : pcnt_reg - 8'h01;
      if (pre_wrap) begin
        cnt_next = (cnt_reg == '0) ? {hi_reg, lo_reg} : cnt_reg - COUNT_W'(1);
      end
    end
    if (!guard && ctl_reg[BIT_RUN] && ctl_reg[BIT_INPUT_EN] && mode == MODE_RETRIG && fall) begin
      cnt_next = {hi_reg, lo_reg};
      pcnt_next = pre_reg;
    end
    if (eoc) begin
      if (guard) begin
        srst_next = 1'b1;
        flag_next = 1'b1;
      end else begin
        if (ctl_reg[BIT_SINGLE]) begin
          ctl_next[BIT_RUN] = 1'b0;
        end
        if (ctl_reg[BIT_OUT_EN]) begin
          out_next = ctl_reg[BIT_OUT_MODE] ? ctl_reg[BIT_WRITE_OUT] : ~out_reg;
        end
        a0_next = ~evr_reg[BIT_A0_SEL];
        top_next = ~evr_reg[BIT_TOP_SEL] & evr_reg[BIT_A0_SEL];
      end
    end
    // watchdog mode: count-routed channels only fire as software traps
    if (guard) begin
      if (!evr_reg[BIT_A0_SEL]) a0_next = a0_pend_set;
      if (!evr_reg[BIT_TOP_SEL]) top_next = top_pend_set & evr_reg[BIT_A0_SEL];
    end
    if (evr_reg[BIT_A0_SEL] && ext_int_pin) a0_next = 1'b1;
    if (evr_reg[BIT_TOP_SEL] && nmi_pin) top_next = 1'b1;
    if (!ctl_reg[BIT_OUT_EN]) begin
      out_next = 1'b1;
    end
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_EXT_VECTOR: begin
          evr_next = reg_wdata;
        end
        ADDR_COUNT_HI: begin
          if (!guard) begin
            hi_next = reg_wdata;
            if (!ctl_reg[BIT_RUN]) cnt_next[15:8] = reg_wdata;
          end
        end
        ADDR_COUNT_LO: begin
          if (guard) begin
            if (reg_wdata == KEY_FIRST) begin
              key_next = KEY_ARMED;
            end else if (reg_wdata == KEY_SECOND && key_reg == KEY_ARMED) begin
              key_next = KEY_IDLE;
              cnt_next = {hi_reg, lo_reg};
              pcnt_next = pre_reg;
              srst_next = 1'b0;
              flag_next = flag_reg;
            end else begin
              key_next = KEY_IDLE;
            end
          end else begin
            lo_next = reg_wdata;
            if (!ctl_reg[BIT_RUN]) cnt_next[7:0] = reg_wdata;
          end
        end
        ADDR_PRESCALE: begin
          // new ratio applies at once, not after the old one runs out
          pre_next = reg_wdata;
          pcnt_next = reg_wdata;
        end
        ADDR_CONTROL: begin
          // a single-mode stop in this cycle is overridden by a restart write
          ctl_next = reg_wdata;
        end
        ADDR_WAIT: begin
          if (!reg_wdata[BIT_GUARD_EN_N]) gen_n_next = 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hi_reg <= RST_COUNT;
      lo_reg <= RST_COUNT;
      pre_reg <= RST_PRESCALE;
      ctl_reg <= RST_CONTROL;
      evr_reg <= RST_EXT_VECTOR;
      gen_n_reg <= RST_WAIT[BIT_GUARD_EN_N];
      hw_reg <= 1'b0;
      strap_reg <= 1'b1;
      cnt_reg <= {RST_COUNT, RST_COUNT};
      pcnt_reg <= RST_PRESCALE;
      div_reg <= 2'h0;
      pin_reg <= 1'b1;
      trig_reg <= 1'b0;
      out_reg <= 1'b1;
      key_reg <= KEY_IDLE;
      flag_reg <= 1'b0;
      srst_reg <= 1'b0;
      top_reg <= 1'b0;
      a0_reg <= 1'b0;
      rd_reg <= 8'h00;
    end else begin
      hi_reg <= hi_next;
      lo_reg <= lo_next;
      pre_reg <= pre_next;
      ctl_reg <= ctl_next;
      evr_reg <= evr_next;
      gen_n_reg <= gen_n_next;
      hw_reg <= hw_next;
      strap_reg <= strap_next;
      cnt_reg <= cnt_next;
      pcnt_reg <= pcnt_next;
      div_reg <= div_next;
      pin_reg <= pin_next;
      trig_reg <= trig_next;
      out_reg <= out_next;
      key_reg <= key_next;
      flag_reg <= flag_next;
      srst_reg <= srst_next;
      top_reg <= top_next;
      a0_reg <= a0_next;
      rd_reg <= rd_next;
    end
  end

  always_comb begin
    reg_rdata = rd_reg;
    top_level_request = top_reg;
    chan_a0_request = a0_reg;
    system_reset_req = srst_reg;
    guard_reset_flag = flag_reg;
    timer_out_pin = out_reg;
  end
endmodule : timer_watchdog_regs_irq

// *** timer_watchdog_regs_irq_bench.sv ***
// self-checking bench for the timer/watchdog block
`timescale 1ns/1ps
module timer_watchdog_regs_irq_bench;
  import wdt_pkg::*;
  logic clk, rst, reg_wr, reg_rd, nmi_pin, ext_int_pin, top_pend_set, a0_pend_set;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic tin, hw_pin;
  logic top_level_request, chan_a0_request, system_reset_req, guard_reset_flag, timer_out_pin;
  int n_fail, n_compared, n_top, n_a0, n_rst, t0, a0, i;
  timer_watchdog_regs_irq u_dut (.clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .timer_in_pin(tin), .nmi_pin, .ext_int_pin, .hw_guard_select_pin(hw_pin), .top_pend_set,
    .a0_pend_set, .top_level_request, .chan_a0_request, .system_reset_req, .guard_reset_flag, .timer_out_pin);
  irq_reset_model u_far (.clk, .top_req(top_level_request), .a0_req(chan_a0_request),
    .sys_req(system_reset_req), .n_top, .n_a0, .n_rst);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // read data is registered, so it is taken one edge later
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk(reg_rdata, exp);
  endtask : rchk
  task automatic pend_a0;
    a0 = n_a0;
    for (i = 0; i < 200 && n_a0 == a0; i++) @(negedge clk);
  endtask : pend_a0
  task close_out;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  initial begin
    #200000;
    n_fail++;
    close_out;
  end
  initial begin
    {rst, reg_wr, reg_rd, nmi_pin, ext_int_pin, top_pend_set, a0_pend_set} = 7'h40;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    tin = 1'b1;
    hw_pin = 1'b1;
    n_fail = 0;
    n_compared = 0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    rchk(ADDR_CONTROL, 8'h12);
    rchk(ADDR_PRESCALE, 8'hff);
    rchk(ADDR_COUNT_HI, 8'hff);
    rchk(ADDR_COUNT_LO, 8'hff);
    rchk(ADDR_WAIT, 8'h7f);
    rchk(ADDR_EXT_VECTOR, 8'h06);
    rchk(8'h00, 8'h00);
    $display("test reset values done");
    wr(ADDR_PRESCALE, 8'h00);
    wr(ADDR_COUNT_HI, 8'h00);
    wr(ADDR_COUNT_LO, 8'h03);
    rchk(ADDR_COUNT_LO, 8'h03);
    wr(ADDR_EXT_VECTOR, 8'h00);
    t0 = n_top;
    wr(ADDR_CONTROL, 8'h80);
    pend_a0;
    pend_a0;
    chk(8'(n_a0 - a0), 8'h01);
    chk(8'(n_top - t0), 8'h00);
    wr(ADDR_CONTROL, 8'hc0);
    pend_a0;
    repeat (2) @(negedge clk);
    rchk(ADDR_CONTROL, 8'h40);
    $display("test timer requests done");
    chk({7'h00, timer_out_pin}, 8'h01);
    wr(ADDR_CONTROL, 8'h85);
    pend_a0;
    chk({7'h00, timer_out_pin}, 8'h00);
    wr(ADDR_CONTROL, 8'h81);
    pend_a0;
    chk({7'h00, timer_out_pin}, 8'h01);
    pend_a0;
    chk({7'h00, timer_out_pin}, 8'h00);
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_COUNT_LO, 8'h03);
    chk({7'h00, timer_out_pin}, 8'h01);
    $display("test output modes done");
    // falls 8 clocks apart: a clock-driven count would expire twice
    wr(ADDR_CONTROL, 8'h88);
    a0 = n_a0;
    repeat (4) begin
      tin = 1'b0;
      repeat (4) @(negedge clk);
      tin = 1'b1;
      repeat (4) @(negedge clk);
    end
    chk(8'(n_a0 - a0), 8'h01);
    tin = 1'b0;
    wr(ADDR_CONTROL, 8'h98);
    a0 = n_a0;
    repeat (40) @(negedge clk);
    chk(8'(n_a0 - a0), 8'h00);
    tin = 1'b1;
    pend_a0;
    chk(8'(n_a0 - a0), 8'h01);
    $display("test input modes done");
    wr(ADDR_EXT_VECTOR, 8'h02);
    t0 = n_top;
    wr(ADDR_CONTROL, 8'h80);
    for (i = 0; i < 200 && n_top == t0; i++) @(negedge clk);
    chk(8'(n_top - t0), 8'h01);
    a0 = n_a0;
    ext_int_pin = 1'b1;
    repeat (3) @(negedge clk);
    ext_int_pin = 1'b0;
    repeat (2) @(negedge clk);
    chk(8'(n_a0 - a0), 8'h03);
    wr(ADDR_EXT_VECTOR, 8'h04);
    // a pulse launched under the old routing is counted first
    @(negedge clk);
    t0 = n_top;
    nmi_pin = 1'b1;
    repeat (2) @(negedge clk);
    nmi_pin = 1'b0;
    repeat (2) @(negedge clk);
    chk(8'(n_top - t0), 8'h02);
    $display("test routing done");
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_COUNT_LO, 8'h40);
    wr(ADDR_EXT_VECTOR, 8'h00);
    wr(ADDR_WAIT, 8'h3f);
    wr(ADDR_WAIT, 8'h7f);
    rchk(ADDR_WAIT, 8'h3f);
    a0 = n_a0;
    a0_pend_set = 1'b1;
    @(negedge clk);
    a0_pend_set = 1'b0;
    repeat (2) @(negedge clk);
    chk(8'(n_a0 - a0), 8'h01);
    for (t0 = 0; t0 < 6; t0++) begin
      repeat (100) @(negedge clk);
      wr(ADDR_COUNT_LO, KEY_FIRST);
      wr(ADDR_COUNT_LO, KEY_SECOND);
    end
    chk(8'(n_rst), 8'h00);
    for (i = 0; i < 400 && n_rst == 0; i++) @(negedge clk);
    chk(8'(i > 240 && i < 280), 8'h01);
    chk(8'(n_rst), 8'h01);
    chk({7'h00, guard_reset_flag}, 8'h01);
    $display("test watchdog done");
    hw_pin = 1'b0;
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk({7'h00, guard_reset_flag}, 8'h00);
    wr(ADDR_COUNT_HI, 8'h12);
    rchk(ADDR_COUNT_HI, 8'hff);
    rchk(ADDR_WAIT, 8'h7f);
    $display("test hardware guard done");
    close_out;
  end
endmodule : timer_watchdog_regs_irq_bench

// *** wdt_check_sva.sv ***
// assertions on the timer/watchdog block ports
`timescale 1ns/1ps
module wdt_check
  import wdt_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic nmi_pin,
  input wire logic ext_int_pin,
  input wire logic top_level_request,
  input wire logic chan_a0_request,
  input wire logic system_reset_req,
  input wire logic guard_reset_flag
);
  logic [1:0] sel_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // shadow of the two select bits, reset 11
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_reg <= 2'h3;
    end else if (reg_wr && reg_addr == ADDR_EXT_VECTOR) begin
      sel_reg <= reg_wdata[2:1];
    end
  end
  property p_pul; system_reset_req |=> !system_reset_req; endproperty
  a_pul: assert property (p_pul) else $error("reset pulse wide");
  property p_flag; system_reset_req |-> guard_reset_flag; endproperty
  a_flag: assert property (p_flag) else $error("flag not set");
  property p_keep; guard_reset_flag |=> guard_reset_flag; endproperty
  a_keep: assert property (p_keep) else $error("flag lost");
  property p_cause; !guard_reset_flag |=> guard_reset_flag == system_reset_req; endproperty
  a_cause: assert property (p_cause) else $error("flag without reset");
  property p_only; sel_reg == 2'h0 && $past(sel_reg) == 2'h0 |-> !top_level_request; endproperty
  a_only: assert property (p_only) else $error("top request with a0");
  property p_top; !$past(rst) && sel_reg[1] && $past(sel_reg[1]) |-> top_level_request == $past(nmi_pin);
  endproperty
  a_top: assert property (p_top) else $error("top not nmi");
  property p_a0; !$past(rst) && sel_reg[0] && $past(sel_reg[0]) |-> chan_a0_request == $past(ext_int_pin);
  endproperty
  a_a0: assert property (p_a0) else $error("a0 not pin");
  property p_a0p; !sel_reg[0] && !$past(sel_reg[0]) && chan_a0_request |=> !chan_a0_request; endproperty
  a_a0p: assert property (p_a0p) else $error("a0 pulse wide");
  c_rst: cover property (system_reset_req);
  c_a0: cover property (chan_a0_request);
  c_top: cover property (top_level_request);
endmodule : wdt_check
bind timer_watchdog_regs_irq wdt_check u_chk (.clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .nmi_pin,
  .ext_int_pin, .top_level_request, .chan_a0_request, .system_reset_req, .guard_reset_flag);

// *** wdt_pkg.sv ***
// constants for the timer/watchdog register block
package wdt_pkg;
  localparam logic [7:0] ADDR_EXT_VECTOR = 8'hf6;
  localparam logic [7:0] ADDR_COUNT_HI = 8'hf8;
  localparam logic [7:0] ADDR_COUNT_LO = 8'hf9;
  localparam logic [7:0] ADDR_PRESCALE = 8'hfa;
  localparam logic [7:0] ADDR_CONTROL = 8'hfb;
  localparam logic [7:0] ADDR_WAIT = 8'hfc;
  localparam logic [7:0] RST_COUNT = 8'hff;
  localparam logic [7:0] RST_PRESCALE = 8'hff;
  localparam logic [7:0] RST_CONTROL = 8'h12;
  localparam logic [7:0] RST_WAIT = 8'h7f;
  localparam logic [7:0] RST_EXT_VECTOR = 8'h06;
  localparam logic [7:0] KEY_FIRST = 8'haa;
  localparam logic [7:0] KEY_SECOND = 8'h55;
  localparam int BIT_RUN = 7;
  localparam int BIT_SINGLE = 6;
  localparam int BIT_MODE_HI = 5;
  localparam int BIT_MODE_LO = 4;
  localparam int BIT_INPUT_EN = 3;
  localparam int BIT_OUT_MODE = 2;
  localparam int BIT_WRITE_OUT = 1;
  localparam int BIT_OUT_EN = 0;
  localparam int BIT_GUARD_EN_N = 6;
  localparam int BIT_TOP_SEL = 2;
  localparam int BIT_A0_SEL = 1;
  localparam int BIT_GUARD_FLAG = 6;
  localparam int CLK_DIV = 4;
  localparam logic [1:0] MODE_EVENT = 2'b00;
  localparam logic [1:0] MODE_GATED = 2'b01;
  localparam logic [1:0] MODE_TRIG = 2'b10;
  localparam logic [1:0] MODE_RETRIG = 2'b11;
  typedef enum logic [1:0] {KEY_IDLE, KEY_ARMED} key_state_t;
endpackage : wdt_pkg
